// file: design/teletext_ctrl_pkg.sv
// constants, field positions and helpers for the teletext control block
// assumes a byte-wide special-function-register port from the controller core
package teletext_ctrl_pkg;
    // register indices on the special-function-register port
    localparam logic [3:0] IDX_DISPLAY_FRAME = 4'h0;
    localparam logic [3:0] IDX_ACQUISITION = 4'h1;
    localparam logic [3:0] IDX_REQ_COLUMN = 4'h2;
    localparam logic [3:0] IDX_REQ_DATA = 4'h3;
    localparam logic [3:0] IDX_EFFECTS = 4'h4;
    localparam logic [3:0] IDX_BOX_NORMAL = 4'h5;
    localparam logic [3:0] IDX_BOX_ALTERNATE = 4'h6;
    localparam logic [3:0] IDX_LAYOUT = 4'h7;
    localparam logic [3:0] IDX_VIDEO_SELECT = 4'h8;
    localparam logic [3:0] IDX_MEM_ROW = 4'h9;
    localparam logic [3:0] IDX_MEM_COLUMN = 4'hA;
    localparam logic [3:0] IDX_MEM_DATA = 4'hB;
    localparam logic [3:0] IDX_BUSY = 4'hD;
    // reset value of every control register
    localparam logic [7:0] REG_RESET = 8'h00;
    // display_frame_control fields
    localparam int B_EXT_PLACEMENT = 0;
    localparam int B_AUTO_FRAME = 1;
    localparam int B_HEADER_ROLL_INHIBIT = 2;
    localparam int B_STATUS_ROW_ONLY = 3;
    localparam int B_FRAME_DISABLE = 4;
    // acquisition_control fields
    localparam int B_RAW_EIGHT_BIT = 0;
    localparam int B_ACQUISITION_INHIBIT = 1;
    localparam int B_ENHANCEMENT_INHIBIT = 2;
    localparam int B_FULL_FIELD = 3;
    localparam int B_FIELD_POLARITY = 4;
    localparam int B_H_POLARITY = 5;
    localparam int B_V_POLARITY = 6;
    // display_effects fields
    localparam int B_BLACK_MESH = 0;
    localparam int B_COLOUR_MESH = 1;
    localparam int B_SEE_THROUGH = 2;
    localparam int B_SHADOW = 3;
    localparam int B_LANGUAGE = 4;
    // box display fields (normal and alternate alike)
    localparam int B_BACKDROP_OUT = 0;
    localparam int B_BACKDROP_IN = 1;
    localparam int B_CONTRAST_OUT = 2;
    localparam int B_CONTRAST_IN = 3;
    localparam int B_TEXT_OUT = 4;
    localparam int B_TEXT_IN = 5;
    localparam int B_PICTURE_OUT = 6;
    localparam int B_PICTURE_IN = 7;
    // display_layout fields
    localparam int B_STATUS_ROW_TOP = 0;
    localparam int B_CURSOR_ON = 1;
    localparam int B_REVEAL = 2;
    localparam int B_TALL_HALF = 3;
    localparam int B_TALL_GLYPH = 4;
    localparam int B_BOX_INFO_ROW = 5;
    localparam int B_BOX_BODY_ROWS = 6;
    localparam int B_BOX_HEADER_ROW = 7;
    // memory_row_pointer fields
    localparam int B_CLEAR_MEMORY = 7;
    localparam int B_BANK = 5;
    // teletext memory geometry and fill value
    localparam int MEM_ADDR_W = 12;
    localparam int MEM_DEPTH = 4096;
    localparam logic [11:0] MEM_LAST = 12'hFFF;
    localparam logic [7:0] MEM_FILL = 8'h20;
    // row 25 control byte holding the newsflash and subtitle flags
    localparam logic [4:0] CONTROL_ROW = 5'h19;
    localparam logic [5:0] FLAG_COLUMN = 6'h08;
    localparam int B_NEWSFLASH = 5;
    localparam int B_SUBTITLE = 6;
    // packet and line limits for acquisition
    localparam logic [4:0] EXT_PACKET = 5'h18;
    localparam logic [4:0] INFO_ROW = 5'h18;
    localparam logic [9:0] FIRST_TEXT_LINE = 10'h002;
    localparam logic [9:0] LAST_TEXT_LINE = 10'h016;
    // request store depth
    localparam int REQ_DEPTH = 8;
    // control state of the memory clearer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CLEAR = 2'b10
    } clear_state_type;
    // flat memory address from bank, row and column
    function automatic logic [11:0] mem_addr(input logic bank, input logic [4:0] row,
                                             input logic [5:0] col);
        mem_addr = {bank, row, col};
    endfunction
endpackage

// file: design/teletext_memory.sv
// teletext memory: 2 banks of 32 rows by 64 columns of bytes
// assumes one arbitrated write port; controller read is immediate
`timescale 1ns/1ns
module teletext_memory
(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [11:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [11:0] cpu_addr,
    output logic [7:0] cpu_data,
    input wire logic [11:0] disp_addr,
    output logic [7:0] disp_data
);
    // storage cells, no reset: contents are set by a clear
    logic [7:0] cells [0:teletext_ctrl_pkg::MEM_DEPTH-1];

    // controller read path, sampled by the register port
    assign cpu_data = cells[cpu_addr];

    // single write port and registered display read
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            cells[wr_addr] <= wr_data;
        end
        disp_data <= cells[disp_addr];
    end
endmodule

// file: design/page_request_store.sv
// small page request store with auto-incrementing write column
// assumes the column load and data write never coincide
`timescale 1ns/1ns
module page_request_store
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic col_load,
    input wire logic [2:0] col_value,
    input wire logic data_wr,
    input wire logic [4:0] data,
    input wire logic [2:0] rd_col,
    output logic [4:0] rd_nibble
);
    logic [4:0] entries [0:teletext_ctrl_pkg::REQ_DEPTH-1]; // request nibbles
    logic [2:0] column; // current write column

    // column pointer load and post-write increment
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            column <= 3'h0;
        end
        else if (col_load)
        begin
            column <= col_value;
        end
        else if (data_wr)
        begin
            column <= column + 3'h1;
        end
    end

    // entry writes and registered read for acquisition
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < teletext_ctrl_pkg::REQ_DEPTH; i++)
            begin
                entries[i] <= 5'h00;
            end
            rd_nibble <= 5'h00;
        end
        else
        begin
            if (data_wr)
            begin
                entries[column] <= data;
            end
            rd_nibble <= entries[rd_col];
        end
    end
endmodule

// file: design/teletext_control_registers.sv
// write-only teletext control registers, memory pointer and data port
// assumes a byte special-function-register port and same-clock acquisition
//
// Operation
// - packet 24 to extension or page memory
// - auto frame off with video; disable holds low
// - header-roll inhibit stops rolling header writes
// - raw mode writes packets 0-24 unchecked
// - acquisition inhibit blocks all acquisition memory writes
// - inhibit automatic packet 26 processing
// - full field selects lines 2-22 or any
// - field, horizontal, vertical sync polarity selection
// - start column for page request writes
// - black mesh, colour mesh, shadow enables
// - black background shown transparent
// - language region selects character set
// - normal box display inside/outside enables
// - alternate box register on newsflash/subtitle
// - status row below or above page
// - cursor at memory row/column pointers
// - reveal shows concealed characters
// - double height with half select
// - box enables for row 0, 1-23, 24
// - select composite video input
// - clear writes 20H everywhere
// - bank, row, column address data port
// - request data auto-increments store column
`timescale 1ns/1ns
module teletext_control_registers
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [3:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    output logic DECODER_PORT_LOCKED,
    input wire logic ACQ_WE,
    input wire logic [4:0] ACQ_PACKET,
    input wire logic [5:0] ACQ_COLUMN,
    input wire logic [7:0] ACQ_BYTE,
    input wire logic ACQ_CHECK_OK,
    input wire logic ACQ_ROLLING,
    input wire logic [9:0] VIDEO_LINE,
    output logic LINE_ACCEPT,
    output logic ENHANCEMENT_PROC_EN,
    input wire logic HSYNC_IN,
    input wire logic VSYNC_IN,
    output logic H_SYNC,
    output logic V_SYNC,
    output logic FIELD_POLARITY,
    input wire logic [2:0] REQ_READ_COL,
    output logic [4:0] REQ_NIBBLE,
    input wire logic VIDEO_SHOWN,
    output logic FRAME_OUT,
    output logic STATUS_ROW_ONLY,
    output logic BLACK_AREA_MESH_EN,
    output logic COLOUR_AREA_MESH_EN,
    output logic SHADOW_EN,
    output logic BLACK_SEE_THROUGH_EN,
    output logic LANGUAGE_REGION_SEL,
    output logic BACKDROP_OUTSIDE_BOX,
    output logic BACKDROP_INSIDE_BOX,
    output logic CONTRAST_CUT_OUTSIDE_BOX,
    output logic CONTRAST_CUT_INSIDE_BOX,
    output logic TEXT_OUTSIDE_BOX,
    output logic TEXT_INSIDE_BOX,
    output logic PICTURE_OUTSIDE_BOX,
    output logic PICTURE_INSIDE_BOX,
    output logic STATUS_ROW_TOP,
    output logic CURSOR_EN,
    output logic [4:0] CURSOR_ROW,
    output logic [5:0] CURSOR_COL,
    output logic HIDDEN_CHARS_SHOW,
    output logic TALL_GLYPH_EN,
    output logic TALL_HALF_SELECT,
    output logic BOXES_HEADER_ROW_EN,
    output logic BOXES_BODY_ROWS_EN,
    output logic BOXES_INFO_ROW_EN,
    output logic COMPOSITE_INPUT_SEL,
    input wire logic DISP_BANK,
    input wire logic [4:0] DISP_ROW,
    input wire logic [5:0] DISP_COL,
    output logic [7:0] DISP_BYTE
);
    // control registers
    logic [7:0] display_frame_control; // frame and roll options
    logic [7:0] acquisition_control; // acquisition gating and sync
    logic [7:0] display_effects; // mesh, shadow, language
    logic [7:0] box_display_normal; // box enables, normal page
    logic [7:0] box_display_alternate; // box enables, newsflash/subtitle
    logic [7:0] display_layout; // row layout, cursor, height
    logic [7:0] video_input_select; // composite input choice
    logic memory_bank_sel; // memory bank pointer
    logic [4:0] memory_row_index; // memory row pointer
    logic [5:0] memory_column_index; // memory column pointer
    logic newsflash; // row 25 newsflash flag copy
    logic subtitle; // row 25 subtitle flag copy
    // memory clearer
    teletext_ctrl_pkg::clear_state_type state; // clearer state
    teletext_ctrl_pkg::clear_state_type next_state; // next clearer state
    logic [11:0] clear_addr; // clear sweep address
    // sync pin synchronisers
    logic [1:0] hsync_sync; // horizontal sync pipe
    logic [1:0] vsync_sync; // vertical sync pipe
    // decode and write port wires
    wire clearing = (state == teletext_ctrl_pkg::ST_CLEAR);
    wire port_open = !clearing;
    wire reg_wr = SFR_WR && port_open;
    wire wr_frame = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_DISPLAY_FRAME);
    wire wr_acq = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_ACQUISITION);
    wire wr_req_col = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_REQ_COLUMN);
    wire wr_req_data = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_REQ_DATA);
    wire wr_effects = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_EFFECTS);
    wire wr_box_norm = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_BOX_NORMAL);
    wire wr_box_alt = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_BOX_ALTERNATE);
    wire wr_layout = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_LAYOUT);
    wire wr_video = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_VIDEO_SELECT);
    wire wr_row = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_MEM_ROW);
    wire wr_col = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_MEM_COLUMN);
    wire wr_data = reg_wr && (SFR_ADDR == teletext_ctrl_pkg::IDX_MEM_DATA);
    wire clear_start = wr_row && SFR_WDATA[teletext_ctrl_pkg::B_CLEAR_MEMORY];
    // pointer address for the data port
    wire [11:0] cpu_addr = teletext_ctrl_pkg::mem_addr(memory_bank_sel, memory_row_index,
                                                       memory_column_index);
    wire [7:0] cpu_byte;
    // acquisition destination: packet 24 may go to extension row 0
    wire acq_to_ext = (ACQ_PACKET == teletext_ctrl_pkg::EXT_PACKET)
                      && !display_frame_control[teletext_ctrl_pkg::B_EXT_PLACEMENT];
    wire [4:0] acq_row = acq_to_ext ? 5'h00 : ACQ_PACKET;
    wire [11:0] acq_addr = teletext_ctrl_pkg::mem_addr(acq_to_ext, acq_row, ACQ_COLUMN);
    wire acq_in_page = (ACQ_PACKET <= teletext_ctrl_pkg::EXT_PACKET);
    wire acq_checked = ACQ_CHECK_OK
                       || acquisition_control[teletext_ctrl_pkg::B_RAW_EIGHT_BIT];
    wire roll_blocked = ACQ_ROLLING
                        && display_frame_control[teletext_ctrl_pkg::B_HEADER_ROLL_INHIBIT];
    wire acq_allowed = ACQ_WE && acq_in_page && acq_checked && !roll_blocked
                       && !acquisition_control[teletext_ctrl_pkg::B_ACQUISITION_INHIBIT];
    // one write port: clear first, then controller, then acquisition
    wire mem_wr_en = clearing || wr_data || acq_allowed;
    wire [11:0] mem_wr_addr = clearing ? clear_addr : (wr_data ? cpu_addr : acq_addr);
    wire [7:0] mem_wr_byte = clearing ? teletext_ctrl_pkg::MEM_FILL
                             : (wr_data ? SFR_WDATA : ACQ_BYTE);
    wire flag_write = mem_wr_en && (mem_wr_addr == teletext_ctrl_pkg::mem_addr(1'b0,
                      teletext_ctrl_pkg::CONTROL_ROW, teletext_ctrl_pkg::FLAG_COLUMN));
    // effective box register and line window
    wire use_alternate = newsflash || subtitle;
    wire [7:0] box_sel = use_alternate ? box_display_alternate : box_display_normal;
    wire line_in_window = (VIDEO_LINE >= teletext_ctrl_pkg::FIRST_TEXT_LINE)
                          && (VIDEO_LINE <= teletext_ctrl_pkg::LAST_TEXT_LINE);
    wire [7:0] read_value = (SFR_ADDR == teletext_ctrl_pkg::IDX_MEM_DATA) ? cpu_byte
                            : ((SFR_ADDR == teletext_ctrl_pkg::IDX_BUSY)
                               ? {7'h00, clearing} : 8'h00);

    // teletext memory
    teletext_memory u_memory
    (
        .clk(CLK),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_byte),
        .cpu_addr(cpu_addr),
        .cpu_data(cpu_byte),
        .disp_addr(teletext_ctrl_pkg::mem_addr(DISP_BANK, DISP_ROW, DISP_COL)),
        .disp_data(DISP_BYTE)
    );

    // page request store
    page_request_store u_request
    (
        .clk(CLK),
        .nrst(NRST),
        .col_load(wr_req_col),
        .col_value(SFR_WDATA[2:0]),
        .data_wr(wr_req_data),
        .data(SFR_WDATA[4:0]),
        .rd_col(REQ_READ_COL),
        .rd_nibble(REQ_NIBBLE)
    );

    // clearer next state
    always_comb
    begin
        next_state = state;
        case (state)
            teletext_ctrl_pkg::ST_IDLE:
            begin
                if (clear_start)
                begin
                    next_state = teletext_ctrl_pkg::ST_CLEAR;
                end
            end
            teletext_ctrl_pkg::ST_CLEAR:
            begin
                if (clear_addr == teletext_ctrl_pkg::MEM_LAST)
                begin
                    next_state = teletext_ctrl_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = teletext_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    // clearer state and sweep address
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state <= teletext_ctrl_pkg::ST_IDLE;
            clear_addr <= 12'h000;
        end
        else
        begin
            state <= next_state;
            clear_addr <= clearing ? clear_addr + 12'h001 : 12'h000;
        end
    end

    // display and acquisition control registers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            display_frame_control <= teletext_ctrl_pkg::REG_RESET;
            acquisition_control <= teletext_ctrl_pkg::REG_RESET;
            display_effects <= teletext_ctrl_pkg::REG_RESET;
            box_display_normal <= teletext_ctrl_pkg::REG_RESET;
            box_display_alternate <= teletext_ctrl_pkg::REG_RESET;
            display_layout <= teletext_ctrl_pkg::REG_RESET;
            video_input_select <= teletext_ctrl_pkg::REG_RESET;
        end
        else
        begin
            if (wr_frame) display_frame_control <= SFR_WDATA;
            if (wr_acq) acquisition_control <= SFR_WDATA;
            if (wr_effects) display_effects <= SFR_WDATA;
            if (wr_box_norm) box_display_normal <= SFR_WDATA;
            if (wr_box_alt) box_display_alternate <= SFR_WDATA;
            if (wr_layout) display_layout <= SFR_WDATA;
            if (wr_video) video_input_select <= SFR_WDATA;
        end
    end

    // memory pointers and row 25 flag copies
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            memory_bank_sel <= 1'b0;
            memory_row_index <= 5'h00;
            memory_column_index <= 6'h00;
            newsflash <= 1'b0;
            subtitle <= 1'b0;
        end
        else
        begin
            if (wr_row)
            begin
                memory_bank_sel <= SFR_WDATA[teletext_ctrl_pkg::B_BANK];
                memory_row_index <= SFR_WDATA[4:0];
            end
            if (wr_col) memory_column_index <= SFR_WDATA[5:0];
            if (flag_write)
            begin
                newsflash <= mem_wr_byte[teletext_ctrl_pkg::B_NEWSFLASH];
                subtitle <= mem_wr_byte[teletext_ctrl_pkg::B_SUBTITLE];
            end
        end
    end

    // sync pin synchronisers, first stage read only by second
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            hsync_sync <= 2'b00;
            vsync_sync <= 2'b00;
        end
        else
        begin
            hsync_sync <= {hsync_sync[0], HSYNC_IN};
            vsync_sync <= {vsync_sync[0], VSYNC_IN};
        end
    end

    // registered read data and status outputs
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            SFR_RDATA <= 8'h00;
            DECODER_PORT_LOCKED <= 1'b0;
            FRAME_OUT <= 1'b0;
            LINE_ACCEPT <= 1'b0;
            H_SYNC <= 1'b0;
            V_SYNC <= 1'b0;
        end
        else
        begin
            if (SFR_RD) SFR_RDATA <= read_value;
            DECODER_PORT_LOCKED <= (next_state == teletext_ctrl_pkg::ST_CLEAR);
            FRAME_OUT <= !display_frame_control[teletext_ctrl_pkg::B_FRAME_DISABLE]
                         && !(display_frame_control[teletext_ctrl_pkg::B_AUTO_FRAME]
                              && VIDEO_SHOWN);
            LINE_ACCEPT <= acquisition_control[teletext_ctrl_pkg::B_FULL_FIELD]
                           || line_in_window;
            H_SYNC <= hsync_sync[1] ^ acquisition_control[teletext_ctrl_pkg::B_H_POLARITY];
            V_SYNC <= vsync_sync[1] ^ acquisition_control[teletext_ctrl_pkg::B_V_POLARITY];
        end
    end

    // register fields driven straight to the display and acquisition
    assign ENHANCEMENT_PROC_EN =
        !acquisition_control[teletext_ctrl_pkg::B_ENHANCEMENT_INHIBIT];
    assign FIELD_POLARITY = acquisition_control[teletext_ctrl_pkg::B_FIELD_POLARITY];
    assign STATUS_ROW_ONLY = display_frame_control[teletext_ctrl_pkg::B_STATUS_ROW_ONLY];
    assign BLACK_AREA_MESH_EN = display_effects[teletext_ctrl_pkg::B_BLACK_MESH];
    assign COLOUR_AREA_MESH_EN = display_effects[teletext_ctrl_pkg::B_COLOUR_MESH];
    assign SHADOW_EN = display_effects[teletext_ctrl_pkg::B_SHADOW];
    assign BLACK_SEE_THROUGH_EN = display_effects[teletext_ctrl_pkg::B_SEE_THROUGH];
    assign LANGUAGE_REGION_SEL = display_effects[teletext_ctrl_pkg::B_LANGUAGE];
    assign BACKDROP_OUTSIDE_BOX = box_sel[teletext_ctrl_pkg::B_BACKDROP_OUT];
    assign BACKDROP_INSIDE_BOX = box_sel[teletext_ctrl_pkg::B_BACKDROP_IN];
    assign CONTRAST_CUT_OUTSIDE_BOX = box_sel[teletext_ctrl_pkg::B_CONTRAST_OUT];
    assign CONTRAST_CUT_INSIDE_BOX = box_sel[teletext_ctrl_pkg::B_CONTRAST_IN];
    assign TEXT_OUTSIDE_BOX = box_sel[teletext_ctrl_pkg::B_TEXT_OUT];
    assign TEXT_INSIDE_BOX = box_sel[teletext_ctrl_pkg::B_TEXT_IN];
    assign PICTURE_OUTSIDE_BOX = box_sel[teletext_ctrl_pkg::B_PICTURE_OUT];
    assign PICTURE_INSIDE_BOX = box_sel[teletext_ctrl_pkg::B_PICTURE_IN];
    assign STATUS_ROW_TOP = display_layout[teletext_ctrl_pkg::B_STATUS_ROW_TOP];
    assign CURSOR_EN = display_layout[teletext_ctrl_pkg::B_CURSOR_ON];
    assign CURSOR_ROW = memory_row_index;
    assign CURSOR_COL = memory_column_index;
    assign HIDDEN_CHARS_SHOW = display_layout[teletext_ctrl_pkg::B_REVEAL];
    assign TALL_GLYPH_EN = display_layout[teletext_ctrl_pkg::B_TALL_GLYPH];
    assign TALL_HALF_SELECT = display_layout[teletext_ctrl_pkg::B_TALL_HALF];
    assign BOXES_HEADER_ROW_EN = display_layout[teletext_ctrl_pkg::B_BOX_HEADER_ROW];
    assign BOXES_BODY_ROWS_EN = display_layout[teletext_ctrl_pkg::B_BOX_BODY_ROWS];
    assign BOXES_INFO_ROW_EN = display_layout[teletext_ctrl_pkg::B_BOX_INFO_ROW];
    assign COMPOSITE_INPUT_SEL = video_input_select[0];
endmodule

// file: tb/teletext_ctrl_monitor.sv
// assertions on the teletext control register port
// assumes a bind onto teletext_control_registers
`timescale 1ns/1ns
module teletext_ctrl_monitor
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [3:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic DECODER_PORT_LOCKED,
    input wire logic ENHANCEMENT_PROC_EN,
    input wire logic COMPOSITE_INPUT_SEL,
    input wire logic TALL_GLYPH_EN,
    input wire logic FRAME_OUT,
    input wire logic [4:0] CURSOR_ROW
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // write accepted while no clear runs
    wire wr_ok = SFR_WR && !DECODER_PORT_LOCKED;
    a_video_sel_load: assert property (wr_ok && SFR_ADDR == 4'h8 |=>
        COMPOSITE_INPUT_SEL == $past(SFR_WDATA[0])) else $error("input select wrong");
    a_enh_inhibit_load: assert property (wr_ok && SFR_ADDR == 4'h1 |=>
        ENHANCEMENT_PROC_EN == !$past(SFR_WDATA[2])) else $error("pkt26 enable wrong");
    a_tall_glyph_load: assert property (wr_ok && SFR_ADDR == 4'h7 |=>
        TALL_GLYPH_EN == $past(SFR_WDATA[4])) else $error("double height wrong");
    a_cursor_row_load: assert property (wr_ok && SFR_ADDR == 4'h9 |=>
        CURSOR_ROW == $past(SFR_WDATA[4:0])) else $error("row pointer wrong");
    a_clear_sets_lock: assert property (wr_ok && SFR_ADDR == 4'h9 && SFR_WDATA[7] |=>
        DECODER_PORT_LOCKED) else $error("clear did not lock");
    a_lock_holds_run: assert property ($rose(DECODER_PORT_LOCKED) |->
        DECODER_PORT_LOCKED[*8]) else $error("lock too short");
    a_locked_write_drop: assert property (SFR_WR && DECODER_PORT_LOCKED && SFR_ADDR == 4'h8
        |=> $stable(COMPOSITE_INPUT_SEL)) else $error("write taken while locked");
    a_frame_disable_low: assert property (wr_ok && SFR_ADDR == 4'h0 && SFR_WDATA[4]
        ##1 !(SFR_WR && SFR_ADDR == 4'h0) |=> !FRAME_OUT) else $error("frame not low");
endmodule
bind teletext_control_registers teletext_ctrl_monitor mon (.CLK, .NRST, .SFR_ADDR, .SFR_WR,
    .SFR_WDATA, .DECODER_PORT_LOCKED, .ENHANCEMENT_PROC_EN, .COMPOSITE_INPUT_SEL,
    .TALL_GLYPH_EN, .FRAME_OUT, .CURSOR_ROW);

// file: tb/tb_top.sv
// self-checking bench for the teletext control registers
// assumes the design files are compiled first
`timescale 1ns/1ns
module tb_top;
    logic CLK = 0, NRST = 0, SFR_WR = 0, SFR_RD = 0, ACQ_WE = 0, rd_seen = 0, DISP_BANK = 0;
    logic ACQ_CHECK_OK = 1, ACQ_ROLLING = 0, HSYNC_IN = 0, VSYNC_IN = 0, VIDEO_SHOWN = 0;
    logic DECODER_PORT_LOCKED, ENHANCEMENT_PROC_EN, COMPOSITE_INPUT_SEL, TALL_GLYPH_EN, FRAME_OUT;
    logic [3:0] SFR_ADDR = 4'h0;
    logic [7:0] SFR_WDATA = 8'h00, ACQ_BYTE = 8'h00, SFR_RDATA, d;
    logic [4:0] ACQ_PACKET = 5'h00, DISP_ROW = 5'h00, CURSOR_ROW, row, REQ_NIBBLE;
    logic [5:0] ACQ_COLUMN = 6'h04, DISP_COL = 6'h00, col;
    logic [9:0] VIDEO_LINE = 10'h000;
    logic [2:0] REQ_READ_COL = 3'h0;
    logic [7:0] q[$];
    int err_total = 0, samples_checked = 0, seed = 33, i;
    teletext_control_registers dut (.CLK, .NRST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
        .SFR_RDATA, .DECODER_PORT_LOCKED, .ACQ_WE, .ACQ_PACKET, .ACQ_COLUMN, .ACQ_BYTE,
        .ACQ_CHECK_OK, .ACQ_ROLLING, .VIDEO_LINE, .LINE_ACCEPT(), .ENHANCEMENT_PROC_EN,
        .HSYNC_IN, .VSYNC_IN, .H_SYNC(), .V_SYNC(), .FIELD_POLARITY(), .REQ_READ_COL,
        .REQ_NIBBLE, .VIDEO_SHOWN, .FRAME_OUT, .STATUS_ROW_ONLY(), .BLACK_AREA_MESH_EN(),
        .COLOUR_AREA_MESH_EN(), .SHADOW_EN(), .BLACK_SEE_THROUGH_EN(), .LANGUAGE_REGION_SEL(),
        .BACKDROP_OUTSIDE_BOX(), .BACKDROP_INSIDE_BOX(), .CONTRAST_CUT_OUTSIDE_BOX(),
        .CONTRAST_CUT_INSIDE_BOX(), .TEXT_OUTSIDE_BOX(), .TEXT_INSIDE_BOX(),
        .PICTURE_OUTSIDE_BOX(), .PICTURE_INSIDE_BOX(), .STATUS_ROW_TOP(), .CURSOR_EN(),
        .CURSOR_ROW, .CURSOR_COL(), .HIDDEN_CHARS_SHOW(), .TALL_GLYPH_EN, .TALL_HALF_SELECT(),
        .BOXES_HEADER_ROW_EN(), .BOXES_BODY_ROWS_EN(), .BOXES_INFO_ROW_EN(),
        .COMPOSITE_INPUT_SEL, .DISP_BANK, .DISP_ROW, .DISP_COL, .DISP_BYTE());
    always #50 CLK = ~CLK;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one port cycle, strobe held for exactly one edge
    task acc(input logic [3:0] a, input logic [7:0] v, input logic r);
        @(posedge CLK);
        #1 {SFR_ADDR, SFR_WDATA, SFR_WR, SFR_RD} = {a, v, !r, r};
        @(posedge CLK);
        #1 {SFR_WR, SFR_RD} = 2'b00;
    endtask
    task rd(input logic [7:0] e);
        q.push_back(e);
        acc(4'hB, 8'h00, 1);
    endtask
    task ptr(input logic b, input logic [4:0] r, input logic [5:0] c);
        acc(4'h9, {2'b00, b, r}, 0);
        acc(4'hA, {2'b00, c}, 0);
    endtask
    task acq(input logic [4:0] p, input logic [7:0] b);
        @(posedge CLK);
        #1 {ACQ_WE, ACQ_PACKET, ACQ_BYTE} = {1'b1, p, b};
        @(posedge CLK);
        #1 ACQ_WE = 0;
    endtask
    // read results compared one edge after the read
    always @(posedge CLK)
    begin
        if (rd_seen)
            chk(SFR_RDATA, q.pop_front());
        rd_seen <= SFR_RD;
    end
    initial
    begin
        #3000000 err_total++;
        stop_test;
    end
    initial
    begin
        repeat (10) @(posedge CLK);
        #1 NRST = 1;
        chk({7'h00, ENHANCEMENT_PROC_EN}, 8'h01);
        acc(4'h9, 8'h80, 0);
        acc(4'h8, 8'h01, 0);
        chk({7'h00, DECODER_PORT_LOCKED}, 8'h01);
        chk({7'h00, COMPOSITE_INPUT_SEL}, 8'h00);
        for (i = 0; i < 5000 && DECODER_PORT_LOCKED !== 1'b0; i++) @(posedge CLK);
        #1 chk({7'h00, DECODER_PORT_LOCKED}, 8'h00);
        ptr(1, 5'h1F, 6'h3F);
        rd(8'h20);
        $display("clear test done");
        for (i = 0; i < 8; i++)
        begin
            {DISP_BANK, DISP_ROW, DISP_COL, REQ_READ_COL, VIDEO_SHOWN, VIDEO_LINE} = $random(seed);
            {HSYNC_IN, VSYNC_IN, d, row, col} = $random(seed);
            ptr(d[7], row, col);
            chk({3'h0, CURSOR_ROW}, {3'h0, row});
            acc(4'hB, d, 0);
            rd(d);
            acc(4'h8, d, 0);
            chk({7'h00, COMPOSITE_INPUT_SEL}, {7'h00, d[0]});
            acc(4'h1, d, 0);
            chk({7'h00, ENHANCEMENT_PROC_EN}, {7'h00, !d[2]});
            acc(4'h7, d, 0);
            chk({7'h00, TALL_GLYPH_EN}, {7'h00, d[4]});
            acc(4'h0, d, 0);
            @(posedge CLK);
            #1 chk({7'h00, FRAME_OUT}, {7'h00, !d[4] && !(d[1] && VIDEO_SHOWN)});
        end
        $display("register test done");
        acc(4'h0, 8'h00, 0);
        acc(4'h1, 8'h00, 0);
        acq(5'h02, 8'h5A);
        ptr(0, 5'h02, 6'h04);
        rd(8'h5A);
        acq(5'h18, 8'h33);
        ptr(1, 5'h00, 6'h04);
        rd(8'h33);
        acc(4'h0, 8'h01, 0);
        acq(5'h18, 8'h3C);
        ptr(0, 5'h18, 6'h04);
        rd(8'h3C);
        acc(4'h1, 8'h02, 0);
        acq(5'h02, 8'hA5);
        ptr(0, 5'h02, 6'h04);
        rd(8'h5A);
        acc(4'h2, 8'h06, 0);
        acc(4'h3, 8'h0B, 0);
        acc(4'h3, 8'h15, 0);
        REQ_READ_COL = 3'h7;
        @(posedge CLK);
        #1 chk({3'h0, REQ_NIBBLE}, 8'h15);
        repeat (3) @(posedge CLK);
        $display("acquisition test done");
        stop_test;
    end
endmodule
